// ---- src/dpram_host_ctrl.sv ----
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module dpram_host_ctrl
  import dpram_host_pkg::*;
#(
  parameter bit IS_LEFT = 1'b1,
  parameter int ACCESS_CYCLES = ACCESS_CYC,
  parameter int SETUP_CYCLES = SETUP_CYC
) (
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  input wire logic [7:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [7:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  output logic IRQ_OUT,
  output logic CE_N_OUT,
  output logic RW_N_OUT,
  output logic OE_N_OUT,
  output logic [ADDR_W-1:0] ADDR_OUT,
  output logic [DATA_W-1:0] DATA_OUT,
  output logic DATA_OE_OUT,
  input wire logic [DATA_W-1:0] DATA_IN,
  input wire logic LEFT_COLLISION_FLAG_N_IN,
  input wire logic RIGHT_COLLISION_FLAG_N_IN,
  input wire logic MAILBOX_FLAG_N_IN
);

  localparam int COUNT_MAX = 15;

  // The one shared counter is four bits wide, so neither count may pass fifteen cycles.
  if (ACCESS_CYCLES < 1 || ACCESS_CYCLES > COUNT_MAX) begin : g_bad_access
    $error("The strobe count must lie between 1 and 15 cycles.");
  end
  if (SETUP_CYCLES < 1 || SETUP_CYCLES > COUNT_MAX) begin : g_bad_setup
    $error("The setup count must lie between 1 and 15 cycles.");
  end

  localparam logic [ADDR_W-1:0] OWN_MBX = IS_LEFT ? MBX_LEFT_ADDR : MBX_RIGHT_ADDR;
  localparam logic [ADDR_W-1:0] PEER_MBX = IS_LEFT ? MBX_RIGHT_ADDR : MBX_LEFT_ADDR;
  localparam logic [3:0] ACCESS_LAST = 4'(ACCESS_CYCLES - 1);
  localparam logic [3:0] SETUP_LAST = 4'(SETUP_CYCLES - 1);

  //////////////////////////////////////////////////////////////////////////////
  // Register bus slave.

  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_held;
  logic w_held;
  logic do_write;
  logic ar_take;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clear;
  logic cmd_start;
  logic [31:0] cmd;
  logic [DATA_W-1:0] rdata;
  state_t state;
  logic own_coll_n;

  // A standing response holds off the next write, so one write at most is under way.
  assign do_write = aw_held && w_held && !S_AXI_BVALID_OUT;
  assign ar_take = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
  assign own_coll_n = IS_LEFT ? LEFT_COLLISION_FLAG_N_IN : RIGHT_COLLISION_FLAG_N_IN;

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      S_AXI_AWREADY_OUT <= 1'b0;
      S_AXI_WREADY_OUT <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT <= RESP_OKAY;
    end else begin
      S_AXI_AWREADY_OUT <= !aw_held && !(S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT);
      S_AXI_WREADY_OUT <= !w_held && !(S_AXI_WVALID_IN && S_AXI_WREADY_OUT);
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR_IN;
      end
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA_IN;
        w_strb <= S_AXI_WSTRB_IN;
      end
      if (do_write) begin
        S_AXI_BVALID_OUT <= 1'b1;
        S_AXI_BRESP_OUT <= (aw_addr == REG_CMD || aw_addr == REG_IRQ_MASK) ? RESP_OKAY
                                                                            : RESP_SLVERR;
      end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
        S_AXI_BVALID_OUT <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        S_AXI_AWREADY_OUT <= 1'b1;
        S_AXI_WREADY_OUT <= 1'b1;
      end
    end
  end

  // A command write while an access is in flight is dropped; software polls pending first.
  assign cmd_start = do_write && aw_addr == REG_CMD && state == ST_IDLE;

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cmd <= 32'h00000000;
      irq_mask <= IRQ_MASK_RESET;
    end else begin
      if (cmd_start) begin
        cmd <= w_data;
      end
      if (do_write && aw_addr == REG_IRQ_MASK && w_strb[0]) begin
        irq_mask <= w_data[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      S_AXI_ARREADY_OUT <= 1'b0;
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_RDATA_OUT <= 32'h00000000;
      S_AXI_RRESP_OUT <= RESP_OKAY;
    end else begin
      if (ar_take) begin
        S_AXI_ARREADY_OUT <= 1'b0;
        S_AXI_RVALID_OUT <= 1'b1;
        S_AXI_RRESP_OUT <= RESP_OKAY;
        // Unused bits read as zero, and an unmapped offset answers with an error.
        S_AXI_RDATA_OUT <= 32'h00000000;
        unique case (S_AXI_ARADDR_IN)
          REG_CMD: S_AXI_RDATA_OUT <= cmd;
          REG_STATUS: begin
            S_AXI_RDATA_OUT[ST_PENDING_BIT] <= state != ST_IDLE;
            S_AXI_RDATA_OUT[ST_OWN_COLL_BIT] <= own_coll_n;
            S_AXI_RDATA_OUT[ST_MBX_FLAG_BIT] <= MAILBOX_FLAG_N_IN;
            S_AXI_RDATA_OUT[ST_RDATA_LSB +: DATA_W] <= rdata;
          end
          REG_IRQ_STATUS: S_AXI_RDATA_OUT[IRQ_W-1:0] <= irq_status;
          REG_IRQ_MASK: S_AXI_RDATA_OUT[IRQ_W-1:0] <= irq_mask;
          default: S_AXI_RRESP_OUT <= RESP_SLVERR;
        endcase
      end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
        S_AXI_RVALID_OUT <= 1'b0;
        S_AXI_ARREADY_OUT <= 1'b1;
      end else if (!S_AXI_RVALID_OUT) begin
        S_AXI_ARREADY_OUT <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status: reading clears, a new event in the same cycle survives.

  logic coll_any_q;
  logic mbx_q;
  logic access_done;

  assign irq_clear = (ar_take && S_AXI_ARADDR_IN == REG_IRQ_STATUS) ? irq_status : '0;

  always_comb begin
    irq_set = '0;
    irq_set[IRQ_DONE] = access_done;
    // Only the fall from both flags high counts, so a long stall raises one event.
    irq_set[IRQ_COLL] = !(LEFT_COLLISION_FLAG_N_IN && RIGHT_COLLISION_FLAG_N_IN) && !coll_any_q;
    irq_set[IRQ_MBX] = !MAILBOX_FLAG_N_IN && mbx_q;
  end

  // Edge memories start at the idle pin levels, so leaving reset makes no false edge.
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      irq_status <= '0;
      coll_any_q <= 1'b0;
      mbx_q <= 1'b1;
      IRQ_OUT <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_set;
      coll_any_q <= !(LEFT_COLLISION_FLAG_N_IN && RIGHT_COLLISION_FLAG_N_IN);
      mbx_q <= MAILBOX_FLAG_N_IN;
      // Built from the next status, so the line rises in the same cycle as the bit.
      IRQ_OUT <= |(((irq_status & ~irq_clear) | irq_set) & irq_mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Memory port sequencer.

  pins_t pins;
  logic [3:0] count;
  logic is_write;
  logic [ADDR_W-1:0] target;

  assign is_write = cmd[CMD_WRITE_BIT];
  // Done needs a last strobe cycle with the flag high; a stalled cycle never ends the access.
  assign access_done = state == ST_STROBE && count == ACCESS_LAST && own_coll_n;

  // The mailbox option picks the peer's slot for writes and our own for reads.
  always_comb begin
    target = w_data[CMD_ADDR_LSB +: ADDR_W];
    if (w_data[CMD_MBX_BIT]) begin
      target = w_data[CMD_WRITE_BIT] ? PEER_MBX : OWN_MBX;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state <= ST_IDLE;
      count <= 4'h0;
      pins <= PINS_IDLE;
      rdata <= 8'h00;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (cmd_start) begin
            pins.ce_n <= 1'b0;
            pins.addr <= target;
            pins.data <= w_data[CMD_DATA_LSB +: DATA_W];
            pins.data_oe <= w_data[CMD_WRITE_BIT];
            count <= 4'h0;
            state <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          // Select and address lead the strobe so this port wins a near tie.
          if (count == SETUP_LAST) begin
            count <= 4'h0;
            pins.rw_n <= !is_write;
            pins.oe_n <= is_write;
            state <= ST_STROBE;
          end else begin
            count <= count + 4'h1;
          end
        end
        ST_STROBE: begin
          // A lost arbitration restarts the strobe count, so the access is held
          // a full strobe time after the other side lets go.
          if (!own_coll_n) begin
            count <= 4'h0;
          end else if (count == ACCESS_LAST) begin
            // The byte is taken on the last strobe cycle, after the full access time.
            if (!is_write) begin
              rdata <= DATA_IN;
            end
            pins.rw_n <= 1'b1;
            pins.oe_n <= 1'b1;
            state <= ST_RECOVER;
          end else begin
            count <= count + 4'h1;
          end
        end
        ST_RECOVER: begin
          // Strobes end a cycle before select, so address and data stay put while they rise.
          pins <= PINS_IDLE;
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // The pins come straight from the sequencer register, with no logic in between.
  assign CE_N_OUT = pins.ce_n;
  assign RW_N_OUT = pins.rw_n;
  assign OE_N_OUT = pins.oe_n;
  assign ADDR_OUT = pins.addr;
  assign DATA_OUT = pins.data;
  assign DATA_OE_OUT = pins.data_oe;

endmodule

// ---- src/dpram_host_pkg.sv ----
package dpram_host_pkg;

  // Clock and pin timing.
  localparam int CLK_MHZ = 25;
  localparam int SETUP_NS = 5;
  localparam int ACCESS_NS = 55;
  localparam int SETUP_CYC_RAW = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int ACCESS_CYC_RAW = (ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int SETUP_CYC = (SETUP_CYC_RAW < 1) ? 1 : SETUP_CYC_RAW;
  localparam int ACCESS_CYC = (ACCESS_CYC_RAW < 1) ? 1 : ACCESS_CYC_RAW;

  // Memory port geometry and the two mailbox locations.
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] MBX_LEFT_ADDR = 10'h3fe;
  localparam logic [ADDR_W-1:0] MBX_RIGHT_ADDR = 10'h3ff;

  // Register map, byte addresses.
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;

  // Command fields.
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_MBX_BIT = 30;
  localparam int CMD_WRITE_BIT = 31;

  // Status fields.
  localparam int ST_PENDING_BIT = 0;
  localparam int ST_OWN_COLL_BIT = 1;
  localparam int ST_MBX_FLAG_BIT = 2;
  localparam int ST_RDATA_LSB = 8;

  // Interrupt bits, shared by status and mask.
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_COLL = 1;
  localparam int IRQ_MBX = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic ce_n;
    logic rw_n;
    logic oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic data_oe;
  } pins_t;

  localparam pins_t PINS_IDLE = '{ce_n: 1'b1, rw_n: 1'b1, oe_n: 1'b1,
                                  addr: 10'h000, data: 8'h00, data_oe: 1'b0};

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_RECOVER
  } state_t;

endpackage

// ---- sim/dpram_dev_model.sv ----
`timescale 1ns/1ps
module dpram_dev_model
  import dpram_host_pkg::*;
(
  input wire logic clk_in,
  input wire pins_t pins_in,
  input wire logic busy_in,
  input wire logic peer_set_in,
  input wire logic peer_clear_in,
  output logic [DATA_W-1:0] data_out,
  output logic left_collision_flag_n,
  output logic right_collision_flag_n,
  output logic left_mailbox_flag_n,
  output logic right_mailbox_flag_n
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] last = 8'h00;
  logic rd;
  logic wr;
  assign left_collision_flag_n = !busy_in;
  assign right_collision_flag_n = 1'b1;
  assign rd = !pins_in.ce_n && !pins_in.oe_n;
  assign wr = !pins_in.ce_n && !pins_in.rw_n && left_collision_flag_n;
  // A bus left floating shows the inverse of its last value, so stale data cannot pass.
  assign data_out = rd ? mem[pins_in.addr] : ~last;
  initial left_mailbox_flag_n = 1'b1;
  initial right_mailbox_flag_n = 1'b1;
  always @(posedge clk_in) begin
    last <= data_out;
    if (wr) begin
      mem[pins_in.addr] <= pins_in.data;
    end
    if (wr && pins_in.addr == MBX_RIGHT_ADDR) begin
      right_mailbox_flag_n <= 1'b0;
    end else if (peer_clear_in) begin
      right_mailbox_flag_n <= 1'b1;
    end
    if (peer_set_in) begin
      left_mailbox_flag_n <= 1'b0;
    end else if (rd && pins_in.addr == MBX_LEFT_ADDR && left_collision_flag_n) begin
      left_mailbox_flag_n <= 1'b1;
    end
  end
endmodule

// ---- sim/dpram_host_chk.sv ----
`timescale 1ns/1ps
module dpram_host_chk
  import dpram_host_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  input wire logic CE_N_OUT,
  input wire logic RW_N_OUT,
  input wire logic OE_N_OUT,
  input wire logic [ADDR_W-1:0] ADDR_OUT,
  input wire logic DATA_OE_OUT,
  input wire logic LEFT_COLLISION_FLAG_N_IN
);
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);
  a_select_setup: assert property (($fell(RW_N_OUT) || $fell(OE_N_OUT)) |-> !$past(CE_N_OUT))
    else $error("strobe without select setup");
  a_strobe_select: assert property ((!RW_N_OUT || !OE_N_OUT) |-> !CE_N_OUT)
    else $error("strobe while deselected");
  a_busy_stall: assert property (!RW_N_OUT && !LEFT_COLLISION_FLAG_N_IN |=> !RW_N_OUT)
    else $error("write strobe dropped while busy");
  a_write_drive: assert property (!RW_N_OUT |-> DATA_OE_OUT && OE_N_OUT)
    else $error("write without data drive");
  a_read_float: assert property (!OE_N_OUT |-> !DATA_OE_OUT && RW_N_OUT)
    else $error("read while driving data");
  a_write_length: assert property ($rose(RW_N_OUT) |-> !$past(RW_N_OUT, 2))
    else $error("write strobe too short");
  a_read_length: assert property ($fell(OE_N_OUT) |-> (!OE_N_OUT) [*2])
    else $error("read strobe too short");
  a_addr_held: assert property (!CE_N_OUT && !$past(CE_N_OUT) |-> $stable(ADDR_OUT))
    else $error("address moved during access");
  a_access_end: assert property ($fell(CE_N_OUT) |-> ##[4:60] CE_N_OUT)
    else $error("access did not end");
  cover property ($rose(RW_N_OUT));
  cover property ($rose(OE_N_OUT));
  cover property (!RW_N_OUT && !LEFT_COLLISION_FLAG_N_IN);
endmodule
bind dpram_host_ctrl dpram_host_chk i_dpram_host_chk (.CLK_SYS_IN(CLK_SYS_IN),
  .RST_N_IN(RST_N_IN), .CE_N_OUT(CE_N_OUT), .RW_N_OUT(RW_N_OUT), .OE_N_OUT(OE_N_OUT),
  .ADDR_OUT(ADDR_OUT), .DATA_OE_OUT(DATA_OE_OUT),
  .LEFT_COLLISION_FLAG_N_IN(LEFT_COLLISION_FLAG_N_IN));

// ---- sim/dpram_host_ctrl_tb_top.sv ----
`timescale 1ns/1ps
module dpram_host_ctrl_tb_top;
  import dpram_host_pkg::*;
  localparam logic [17:0] ROWS [4] = '{18'h0003c, 18'h155a5, 18'h3fe5a, 18'h3ffc3};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic [31:0] s;
  logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, busy = 0, pset = 0, pclr = 0;
  logic [3:0] ws = 4'hf;
  logic awr, wrdy, bv, arr, rv, irq, ce_n, rw_n, oe_n, doe, lb_n, rb_n, mb_n, rmb_n;
  logic [1:0] br, rr;
  logic [9:0] ad;
  logic [7:0] dq, din;
  pins_t pins;
  int n_mismatch = 0;
  int n_compared = 0;
  int i;
  always #20 clk = ~clk;
  assign pins = '{ce_n: ce_n, rw_n: rw_n, oe_n: oe_n, addr: ad, data: dq, data_oe: doe};
  dpram_host_ctrl i_dpram_host_ctrl (.CLK_SYS_IN(clk), .RST_N_IN(rst_n),
    .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
    .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(ws), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrdy),
    .S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bry),
    .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
    .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rr), .S_AXI_RVALID_OUT(rv),
    .S_AXI_RREADY_IN(rry), .IRQ_OUT(irq), .CE_N_OUT(ce_n), .RW_N_OUT(rw_n), .OE_N_OUT(oe_n),
    .ADDR_OUT(ad), .DATA_OUT(dq), .DATA_OE_OUT(doe), .DATA_IN(din),
    .LEFT_COLLISION_FLAG_N_IN(lb_n), .RIGHT_COLLISION_FLAG_N_IN(rb_n), .MAILBOX_FLAG_N_IN(mb_n));
  dpram_dev_model i_dpram_dev_model (.clk_in(clk), .pins_in(pins), .busy_in(busy),
    .peer_set_in(pset), .peer_clear_in(pclr), .data_out(din), .left_collision_flag_n(lb_n),
    .right_collision_flag_n(rb_n), .left_mailbox_flag_n(mb_n), .right_mailbox_flag_n(rmb_n));
  ////////////////////////////////////////////////////////////////////////////////
  task close_out;
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task hang;
    n_mismatch++;
    close_out;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Handshakes are sampled at the falling edge, where the slave's outputs are settled.
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    int k;
    tb = 0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    for (k = 0; !tb; k++) begin
      if (k > 200) hang;
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wrdy;
      tb = bv;
      r = br;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb) bry <= 1'b0;
    end
    chk(32'(r), 32'(er));
  endtask
  task rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    logic ta, tr;
    logic [1:0] r;
    int k;
    tr = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (k = 0; !tr; k++) begin
      if (k > 200) hang;
      @(negedge clk);
      ta = arv && arr;
      tr = rv;
      d = rdata;
      r = rr;
      @(posedge clk);
      if (ta) arv <= 1'b0;
      if (tr) rry <= 1'b0;
    end
    chk(32'(r), 32'(er));
  endtask
  task wait_done;
    logic [31:0] st;
    int k;
    st = 0;
    for (k = 0; !st[IRQ_DONE]; k++) begin
      if (k > 50) hang;
      rd(REG_IRQ_STATUS, RESP_OKAY, st);
    end
  endtask
  task cmd(input logic [31:0] c);
    wr(REG_CMD, c, RESP_OKAY);
    wait_done;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(REG_IRQ_MASK, RESP_OKAY, s);
    chk(s, 32'h0);
    rd(8'h10, RESP_SLVERR, s);
    wr(REG_STATUS, 32'h0, RESP_SLVERR);
    ws <= 4'h0;
    wr(REG_IRQ_MASK, 32'h7, RESP_OKAY);
    ws <= 4'hf;
    rd(REG_IRQ_MASK, RESP_OKAY, s);
    chk(s, 32'h0);
    for (i = 0; i < 4; i++) begin
      cmd({1'b1, 1'b0, 12'h000, ROWS[i]});
      chk(32'(i_dpram_dev_model.mem[ROWS[i][17:8]]), 32'(ROWS[i][7:0]));
      cmd({1'b0, 1'b0, 12'h000, ROWS[i][17:8], 8'h00});
      rd(REG_STATUS, RESP_OKAY, s);
      chk(32'(s[15:8]), 32'(ROWS[i][7:0]));
    end
    busy <= 1'b1;
    wr(REG_CMD, {1'b1, 1'b0, 12'h000, 10'h010, 8'h77}, RESP_OKAY);
    repeat (6) @(posedge clk);
    rd(REG_STATUS, RESP_OKAY, s);
    chk(32'(s[2:0]), 32'h5);
    rd(REG_IRQ_STATUS, RESP_OKAY, s);
    chk(32'(s[2:0]), 32'h2);
    busy <= 1'b0;
    wait_done;
    chk(32'(i_dpram_dev_model.mem[10'h010]), 32'h77);
    wr(REG_IRQ_MASK, 32'h4, RESP_OKAY);
    pset <= 1'b1;
    pclr <= 1'b1;
    @(posedge clk);
    pset <= 1'b0;
    pclr <= 1'b0;
    repeat (4) @(negedge clk);
    chk(32'(irq), 32'h1);
    rd(REG_IRQ_STATUS, RESP_OKAY, s);
    chk(32'(s[2:0]), 32'h4);
    cmd({1'b0, 1'b1, 30'h0});
    rd(REG_STATUS, RESP_OKAY, s);
    chk(32'(s[2]), 32'h1);
    chk(32'(rmb_n), 32'h1);
    cmd({1'b1, 1'b1, 22'h0, 8'h96});
    chk(32'(i_dpram_dev_model.mem[10'h3ff]), 32'h96);
    chk(32'(rmb_n), 32'h0);
    wr(REG_IRQ_MASK, 32'h0, RESP_OKAY);
    pset <= 1'b1;
    @(posedge clk);
    pset <= 1'b0;
    repeat (4) @(negedge clk);
    chk(32'(irq), 32'h0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(negedge clk);
    chk(32'({irq, ce_n, rw_n, oe_n, doe, awr, arr, bv, rv}), 32'he0);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(REG_STATUS, RESP_OKAY, s);
    chk(s, 32'h2);
    close_out;
  end
endmodule
